/* File: src/serial_port_pkg.sv */
// Shared constants and phase-length helpers for the serial port clocking block
package serial_port_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int H_NS          = CLK_PERIOD_NS / 2;
  localparam int DIV_W         = 8;
  localparam int WORD_BITS     = 16;
  // One CPU cycle is two half-cycles, so 2H is a whole number of clocks
  localparam logic [DIV_W:0] CYC_PER_2H = (DIV_W+1)'((2 * H_NS) / CLK_PERIOD_NS);

  // ==========================================================================
  // Mode encodings and the divide value forced in SPI slave mode
  localparam logic [1:0]       CSTOP_SPI = 2'h2;
  localparam logic [1:0]       DLY_0     = 2'h0;
  localparam logic [1:0]       DLY_1     = 2'h1;
  localparam logic [DIV_W-1:0] SLAVE_DIV = 8'h01;

  // ==========================================================================
  // General-purpose pin vector positions
  localparam int GPI_RXCLK = 0;
  localparam int GPI_RXFS  = 1;
  localparam int GPI_RXD   = 2;
  localparam int GPI_TXCLK = 3;
  localparam int GPI_TXFS  = 4;
  localparam int GPO_RXCLK = 0;
  localparam int GPO_RXFS  = 1;
  localparam int GPO_TXCLK = 2;
  localparam int GPO_TXFS  = 3;
  localparam int GPO_TXD   = 4;

  // ==========================================================================
  // Phase lengths in clocks; a zero divide value runs as one, since a
  // half-cycle phase cannot be made from this clock
  function automatic logic [DIV_W:0] eff_div(input logic [DIV_W-1:0] div);
    return (div == '0) ? (DIV_W+1)'(1) : {1'b0, div};
  endfunction

  function automatic logic [DIV_W:0] low_cycles(input logic [DIV_W-1:0] div);
    logic [DIV_W:0] d;
    d = eff_div(div);
    if (d[0])
      return ((d + 1'b1) >> 1) * CYC_PER_2H;
    return (d >> 1) * CYC_PER_2H;
  endfunction

  function automatic logic [DIV_W:0] high_cycles(input logic [DIV_W-1:0] div);
    logic [DIV_W:0] d;
    d = eff_div(div);
    if (d[0])
      return ((d + 1'b1) >> 1) * CYC_PER_2H;
    return ((d >> 1) + 1'b1) * CYC_PER_2H;
  endfunction

endpackage

/* File: src/bit_clock_gen.sv */
// Internal bit clock generator with divide-controlled period and duty
`timescale 1ns/10ps
module bit_clock_gen
  import serial_port_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             run_i,
  input  wire logic [DIV_W-1:0] div_i,
  output logic                  level_o,
  output logic                  rise_o,
  output logic                  fall_o
);

  logic [DIV_W:0] cnt_r;
  logic           level_r;

  // ==========================================================================
  // Phase counter
  wire [DIV_W:0] phase_len = level_r ? high_cycles(div_i) : low_cycles(div_i); // R2 R3
  // Compare with >= so a smaller divide value takes effect at once
  wire           phase_end = run_i && (cnt_r >= phase_len - (DIV_W+1)'(1));  // R1

  assign rise_o  = phase_end && !level_r;
  assign fall_o  = phase_end && level_r;
  assign level_o = level_r;

  always_ff @(posedge clk_i) begin
    if (srst_i || !run_i) begin
      cnt_r   <= '0;
      level_r <= 1'b0;
    end else if (phase_end) begin
      cnt_r   <= '0;
      level_r <= !level_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // ==========================================================================
  // Checks
  logic [DIV_W:0] hold_r;
  logic [DIV_W:0] per_r;
  logic           per_ok_r;
  wire  [DIV_W:0] div_x  = {1'b0, div_i};
  wire  [DIV_W:0] lo_exp = div_i[0] ? ((div_x + 1'b1) >> 1) : (div_x >> 1);
  wire  [DIV_W:0] hi_exp = div_i[0] ? ((div_x + 1'b1) >> 1) : ((div_x >> 1) + 1'b1);

  always_ff @(posedge clk_i) begin
    if (srst_i || !run_i || rise_o || fall_o)
      hold_r <= '0;
    else
      hold_r <= hold_r + 1'b1;
    if (srst_i || !run_i) begin
      per_r    <= '0;
      per_ok_r <= 1'b0;
    end else if (rise_o) begin
      per_r    <= '0;
      per_ok_r <= 1'b1;
    end else begin
      per_r <= per_r + 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_low_phase_len: assert property (rise_o && div_i != '0 |-> hold_r == lo_exp - 1'b1) // R2
    else $error("bit clock low phase has wrong length");
  a_high_phase_len: assert property (fall_o && div_i != '0 |-> hold_r == hi_exp - 1'b1) // R3
    else $error("bit clock high phase has wrong length");
  a_period_len: assert property (rise_o && per_ok_r && div_i != '0 |-> per_r == div_x) // R1
    else $error("bit clock period is not divide value plus one");

endmodule

/* File: src/pin_sampler.sv */
// Registers one incoming serial pin, applies polarity and flags its edges
`timescale 1ns/10ps
module pin_sampler (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic pin_i,
  input  wire logic invert_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);

  logic cur_r;
  logic prev_r;

  // Pins are synchronous to clk_i, so a single stage is enough
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      // Start from the pin's own level so no false edge follows reset
      cur_r  <= pin_i ^ invert_i;
      prev_r <= pin_i ^ invert_i;
    end else begin
      cur_r  <= pin_i ^ invert_i;
      prev_r <= cur_r;
    end
  end

  assign level_o = cur_r;
  assign rise_o  = cur_r && !prev_r;
  assign fall_o  = !cur_r && prev_r;

endmodule

/* File: src/serial_port_clocking.sv */
// Serial port clocking, framing, SPI clock-stop and pin GPIO logic
// What this block does
// R1: Generated bit clock period is divide value plus one, times 2H; a zero divide runs as one, giving 2 times 2H.
// R2: Low phase is half period for odd or zero divide, else divide/2 times 2H.
// R3: High phase is half period for odd or zero divide, else (divide/2+1) times 2H.
// R4: A polarity select set to one inverts that signal and its reference edge.
// R5: Internal receive frame sync changes after a receive clock rising edge.
// R6: In framed mode, internal transmit frame sync changes after a transmit clock rising edge.
// R7: Framed mode launches each transmit bit on a transmit clock rising edge.
// R8: Only data delay zero drives the first bit straight from frame sync.
// R9: No transmit delay enable and no alternate-bit mode exist.
// R10: Pins used as general inputs are sampled on the CPU clock rising edge.
// R11: Pins used as general outputs change after the CPU clock rising edge.
// R12: SPI mode launches data on rising clock edges, captures on falling edges.
// R13: SPI master drives transmit clock and frame, not receive clock and frame; receive pins still drive when rx_clock_dir_i or rx_frame_dir_i is set.
// R14: SPI slave takes all clocks and frames from outside.
// R15: SPI slave forces the generator to CPU clock source, divide value one.
// R16: SPI master with frame polarity one drives an active-low select.
// R17: SPI slave with frame polarity one inverts the active-low select input before using it.
// R18: Select goes low before the first rising edge that starts the transfer.
// R19: SPI master releases the data pin after the last bit's falling edge.
// R20: SPI slave releases the data pin when select returns high.
// R21: Framed mode captures each receive bit on a receive clock falling edge.
`timescale 1ns/10ps
module serial_port_clocking
  import serial_port_pkg::*;
#(
  parameter int W = WORD_BITS
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic [DIV_W-1:0] clock_divide_value_i,
  input  wire logic             srg_source_select_i,
  input  wire logic             tx_clock_dir_i,
  input  wire logic             rx_clock_dir_i,
  input  wire logic             tx_frame_dir_i,
  input  wire logic             rx_frame_dir_i,
  input  wire logic             tx_clock_polarity_i,
  input  wire logic             rx_clock_polarity_i,
  input  wire logic             tx_frame_polarity_i,
  input  wire logic             rx_frame_polarity_i,
  input  wire logic [1:0]       clock_stop_select_i,
  input  wire logic [1:0]       tx_data_delay_i,
  input  wire logic             tx_gpio_i,
  input  wire logic             rx_gpio_i,
  input  wire logic [4:0]       gpio_out_i,
  output logic      [4:0]       gpio_in_o,
  input  wire logic [W-1:0]     tx_word_i,
  input  wire logic             tx_start_i,
  output logic                  tx_busy_o,
  input  wire logic             rx_start_i,
  output logic      [W-1:0]     rx_word_o,
  output logic                  rx_valid_o,
  input  wire logic             tx_bit_clock_i,
  output logic                  tx_bit_clock_o,
  output logic                  tx_bit_clock_oe_o,
  input  wire logic             tx_frame_sync_i,
  output logic                  tx_frame_sync_o,
  output logic                  tx_frame_sync_oe_o,
  input  wire logic             rx_bit_clock_i,
  output logic                  rx_bit_clock_o,
  output logic                  rx_bit_clock_oe_o,
  input  wire logic             rx_frame_sync_i,
  output logic                  rx_frame_sync_o,
  output logic                  rx_frame_sync_oe_o,
  output logic                  serial_tx_pin_o,
  output logic                  serial_tx_pin_oe_o,
  input  wire logic             serial_rx_pin_i,
  output logic                  srg_clock_out_o
);

  localparam int BW = $clog2(W + 1);
  localparam logic [BW-1:0] LAST_BIT = BW'(W - 1);

  typedef enum logic [1:0] {TX_IDLE, TX_DELAY, TX_SHIFT} tx_state_type;

  tx_state_type   tx_state_r, tx_state_nxt;
  logic [W-1:0]   tx_hold_r, tx_sh_r, tx_sh_nxt;
  logic [BW-1:0]  tx_bits_r, tx_bits_nxt;
  logic [1:0]     tx_dly_r, tx_dly_nxt;
  logic           tx_oe_r, tx_oe_nxt;
  logic           tx_fs_r, tx_fs_nxt;
  logic           tx_pend_r, tx_pend_nxt;
  logic [W-1:0]   rx_sh_r, rx_word_r;
  logic [BW-1:0]  rx_bits_r;
  logic           rx_act_r, rx_valid_r, rx_fs_r, rx_pend_r;
  logic [4:0]     gpo_r, gpi_r;

  // ==========================================================================
  // Mode decode
  wire spi_mode   = (clock_stop_select_i == CSTOP_SPI);
  wire spi_master = spi_mode && tx_clock_dir_i && tx_frame_dir_i;                  // R13
  wire spi_slave  = spi_mode && !tx_clock_dir_i && !tx_frame_dir_i
                    && !rx_clock_dir_i && !rx_frame_dir_i;                         // R14
  wire [DIV_W-1:0] gen_div = spi_slave ? SLAVE_DIV : clock_divide_value_i;       // R15
  wire gen_src  = srg_source_select_i || spi_slave;                               // R15
  // SPI master clocks only while a word is on the wire; as slave it free-runs at half rate
  wire gen_run  = gen_src && (spi_mode ? (spi_slave || (spi_master && tx_state_r != TX_IDLE))
                                       : (tx_clock_dir_i || rx_clock_dir_i));   // R15

  // ==========================================================================
  // Clock sources and pin sampling
  logic gen_level, gen_rise, gen_fall;
  logic txc_rise, txc_fall, rxc_rise, rxc_fall;
  logic txf_level, txf_rise, rxf_level;

  bit_clock_gen u_gen (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .run_i   (gen_run),
    .div_i   (gen_div),
    .level_o (gen_level),
    .rise_o  (gen_rise),
    .fall_o  (gen_fall)
  );

  pin_sampler u_txc (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .pin_i    (tx_bit_clock_i),
    .invert_i (tx_clock_polarity_i),
    .level_o  (),
    .rise_o   (txc_rise),
    .fall_o   (txc_fall)
  );

  pin_sampler u_txf (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .pin_i    (tx_frame_sync_i),
    .invert_i (tx_frame_polarity_i),
    .level_o  (txf_level),
    .rise_o   (txf_rise),
    .fall_o   ()
  );

  pin_sampler u_rxc (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .pin_i    (rx_bit_clock_i),
    .invert_i (rx_clock_polarity_i),
    .level_o  (),
    .rise_o   (rxc_rise),
    .fall_o   (rxc_fall)
  );

  pin_sampler u_rxf (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .pin_i    (rx_frame_sync_i),
    .invert_i (rx_frame_polarity_i),
    .level_o  (rxf_level),
    .rise_o   (),
    .fall_o   ()
  );

  wire tx_rise = !tx_gpio_i && (tx_clock_dir_i ? gen_rise : txc_rise);            // R4
  wire tx_fall = !tx_gpio_i && (tx_clock_dir_i ? gen_fall : txc_fall);            // R4
  // SPI receive shares the transmit clock; framed receive has its own
  wire rx_rise = !rx_gpio_i && (spi_mode ? tx_rise
                                         : (rx_clock_dir_i ? gen_rise : rxc_rise));
  wire rx_fall = !rx_gpio_i && (spi_mode ? tx_fall
                                         : (rx_clock_dir_i ? gen_fall : rxc_fall));
  wire slave_sel = txf_level;                                                      // R17
  wire rx_fs_eff = rx_frame_dir_i ? rx_fs_r : rxf_level;

  // ==========================================================================
  // Transmit sequencing
  wire [1:0] eff_dly = spi_mode ? DLY_1 : (tx_data_delay_i[1] ? 2'h2 : tx_data_delay_i);
  wire trig_int = !spi_mode && tx_frame_dir_i && tx_pend_r && tx_rise;             // R6
  wire trig_ext = !spi_mode && !tx_frame_dir_i && tx_pend_r && txf_rise;
  wire trig_mst = spi_master && tx_pend_r;                                         // R18
  wire trig_slv = spi_slave && txf_rise;
  wire trigger  = trig_int || trig_ext || trig_mst || trig_slv;
  wire rx_cap   = spi_mode ? (rx_fall && tx_state_r == TX_SHIFT && rx_bits_r < BW'(W))
                           : (rx_fall && rx_act_r);                                // R12 R21
  wire rx_done  = rx_cap && rx_bits_r == LAST_BIT;

  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_sh_nxt    = tx_sh_r;
    tx_bits_nxt  = tx_bits_r;
    tx_dly_nxt   = tx_dly_r;
    tx_oe_nxt    = tx_oe_r;
    tx_fs_nxt    = tx_fs_r;
    tx_pend_nxt  = tx_pend_r || tx_start_i;
    // Framed sync lasts one bit period
    if (!spi_mode && tx_rise)
      tx_fs_nxt = 1'b0;                                                            // R6
    case (tx_state_r)
      TX_IDLE: begin
        if (trigger) begin
          tx_pend_nxt = 1'b0;
          if (trig_int || trig_mst)
            tx_fs_nxt = 1'b1;                                                      // R6 R16
          if (eff_dly == DLY_0) begin
            tx_sh_nxt    = tx_hold_r;                                              // R8
            tx_oe_nxt    = 1'b1;
            tx_bits_nxt  = LAST_BIT;
            tx_state_nxt = TX_SHIFT;
          end else begin
            tx_dly_nxt   = eff_dly;
            tx_state_nxt = TX_DELAY;
          end
        end
      end
      TX_DELAY: begin
        if (tx_rise) begin
          if (tx_dly_r == DLY_1) begin
            tx_sh_nxt    = tx_hold_r;                                              // R7 R12
            tx_oe_nxt    = 1'b1;
            tx_bits_nxt  = LAST_BIT;
            tx_state_nxt = TX_SHIFT;
          end else begin
            tx_dly_nxt = tx_dly_r - 1'b1;
          end
        end
      end
      TX_SHIFT: begin
        if (tx_rise) begin
          if (tx_bits_r != '0) begin
            tx_sh_nxt   = {tx_sh_r[W-2:0], 1'b0};                                 // R7 R12
            tx_bits_nxt = tx_bits_r - 1'b1;
          end else if (!spi_mode) begin
            tx_oe_nxt    = 1'b0;
            tx_state_nxt = TX_IDLE;
          end
        end
      end
      default: tx_state_nxt = TX_IDLE;
    endcase
    // SPI ends override the shifting above
    if (spi_master && rx_done) begin
      tx_oe_nxt    = 1'b0;                                                         // R19
      tx_fs_nxt    = 1'b0;
      tx_state_nxt = TX_IDLE;
    end
    if ((spi_slave && !slave_sel) || (spi_mode && !spi_master && !spi_slave)) begin
      tx_oe_nxt    = 1'b0;                                                         // R20
      tx_state_nxt = TX_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_state_r <= TX_IDLE;
      tx_hold_r  <= '0;
      tx_sh_r    <= '0;
      tx_bits_r  <= '0;
      tx_dly_r   <= '0;
      tx_oe_r    <= 1'b0;
      tx_fs_r    <= 1'b0;
      tx_pend_r  <= 1'b0;
    end else begin
      tx_state_r <= tx_state_nxt;
      tx_hold_r  <= tx_start_i ? tx_word_i : tx_hold_r;
      tx_sh_r    <= tx_sh_nxt;
      tx_bits_r  <= tx_bits_nxt;
      tx_dly_r   <= tx_dly_nxt;
      tx_oe_r    <= tx_oe_nxt;
      tx_fs_r    <= tx_fs_nxt;
      tx_pend_r  <= tx_pend_nxt;
    end
  end

  // ==========================================================================
  // Receive framing and capture
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_fs_r   <= 1'b0;
      rx_pend_r <= 1'b0;
    end else if (rx_rise && !spi_mode && rx_frame_dir_i) begin
      rx_fs_r   <= rx_pend_r || rx_start_i;                                        // R5
      rx_pend_r <= 1'b0;
    end else begin
      rx_pend_r <= rx_pend_r || rx_start_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_act_r   <= 1'b0;
      rx_bits_r  <= '0;
      rx_sh_r    <= '0;
      rx_word_r  <= '0;
      rx_valid_r <= 1'b0;
    end else begin
      rx_valid_r <= rx_done;
      if (rx_cap) begin
        rx_sh_r   <= {rx_sh_r[W-2:0], serial_rx_pin_i};                            // R21 R12
        rx_bits_r <= rx_bits_r + 1'b1;
      end else if (spi_mode ? tx_state_r == TX_IDLE : !rx_act_r) begin
        rx_bits_r <= '0;
      end
      if (rx_done) begin
        rx_word_r <= {rx_sh_r[W-2:0], serial_rx_pin_i};
        rx_act_r  <= 1'b0;
      end else if (!spi_mode && !rx_act_r && rx_fall && rx_fs_eff) begin
        rx_act_r <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // General-purpose pin registers, both timed by the CPU clock rising edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      gpo_r <= '0;
      gpi_r <= '0;
    end else begin
      gpo_r <= gpio_out_i;                                                         // R11
      gpi_r <= {tx_frame_sync_i, tx_bit_clock_i, serial_rx_pin_i,
                rx_frame_sync_i, rx_bit_clock_i};                                  // R10
    end
  end

  // ==========================================================================
  // Pin drive
  assign tx_bit_clock_o     = tx_gpio_i ? gpo_r[GPO_TXCLK] : (gen_level ^ tx_clock_polarity_i);
  assign tx_bit_clock_oe_o  = tx_clock_dir_i;
  assign tx_frame_sync_o    = tx_gpio_i ? gpo_r[GPO_TXFS] : (tx_fs_r ^ tx_frame_polarity_i); // R16
  assign tx_frame_sync_oe_o = tx_frame_dir_i;
  assign rx_bit_clock_o     = rx_gpio_i ? gpo_r[GPO_RXCLK] : (gen_level ^ rx_clock_polarity_i);
  assign rx_bit_clock_oe_o  = rx_clock_dir_i;
  assign rx_frame_sync_o    = rx_gpio_i ? gpo_r[GPO_RXFS] : (rx_fs_r ^ rx_frame_polarity_i);
  assign rx_frame_sync_oe_o = rx_frame_dir_i;
  // Data leaves straight from the shift register, with no extra delay stage
  assign serial_tx_pin_o    = tx_gpio_i ? gpo_r[GPO_TXD] : tx_sh_r[W-1];           // R9
  assign serial_tx_pin_oe_o = tx_gpio_i || tx_oe_r;
  assign gpio_in_o          = gpi_r;
  assign srg_clock_out_o    = gen_level;
  assign tx_busy_o          = tx_pend_r || (tx_state_r != TX_IDLE);
  assign rx_word_o          = rx_word_r;
  assign rx_valid_o         = rx_valid_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_tx_fs_edge: assert property ($changed(tx_fs_r) && !$past(spi_mode) |-> $past(tx_rise)) // R6
    else $error("transmit frame sync moved off a rising edge");
  a_rx_fs_edge: assert property ($changed(rx_fs_r) |-> $past(rx_rise)) // R5
    else $error("receive frame sync moved off a rising edge");
  a_tx_launch_edge: assert property (
    $changed(tx_sh_r) && $past(tx_state_r) == TX_SHIFT |-> $past(tx_rise)) // R7
    else $error("transmit bit launched off a rising edge");
  a_zero_delay_only: assert property (
    $past(tx_state_r) == TX_IDLE && tx_state_r == TX_SHIFT
    |-> $past(tx_data_delay_i) == DLY_0 && !$past(spi_mode)) // R8
    else $error("first bit launched from frame sync without zero delay");
  a_rx_capture_edge: assert property (
    $changed(rx_bits_r) && rx_bits_r != '0 |-> $past(rx_fall)) // R21
    else $error("receive bit captured off a falling edge");
  a_select_first: assert property (
    spi_master && tx_frame_polarity_i && !tx_gpio_i && tx_pend_r && tx_state_r == TX_IDLE
    |=> !tx_frame_sync_o && !gen_level ##1 !tx_frame_sync_o) // R16
    else $error("select not low ahead of the first clock edge");
  a_master_release: assert property (spi_master && rx_done |=> !tx_oe_r && !tx_fs_r) // R19
    else $error("master kept data or select after the last bit");
  a_slave_release: assert property (spi_slave && !slave_sel |=> !serial_tx_pin_oe_o || tx_gpio_i) // R20
    else $error("slave kept driving data with select high");
  a_gpio_out_edge: assert property (tx_gpio_i ##1 tx_gpio_i |-> serial_tx_pin_o == $past(gpio_out_i[GPO_TXD])) // R11
    else $error("general output did not follow one edge later");
  a_gpio_in_edge: assert property (1'b1 |=> gpio_in_o[GPI_RXD] == $past(serial_rx_pin_i)) // R10
    else $error("general input not sampled on the clock edge");

  c_spi_master_word: cover property (spi_master && rx_done);
  c_spi_slave_word: cover property (spi_slave && rx_done);
  c_framed_tx_end: cover property (!spi_mode && tx_state_r == TX_SHIFT ##1 tx_state_r == TX_IDLE);
  c_framed_rx_word: cover property (!spi_mode && rx_valid_o);

endmodule

/* File: sim/spi_peer_model.sv */
// Behavioural SPI peer on the far side of the serial pins
`timescale 1ns/10ps
module spi_peer_model
  import serial_port_pkg::*;
(
  input  wire logic                 sclk_i,
  input  wire logic                 sel_n_i,
  input  wire logic                 sdo_i,
  input  wire logic [WORD_BITS-1:0] word_i,
  output logic                      sdi_o,
  output logic      [WORD_BITS-1:0] got_o
);
  logic [WORD_BITS-1:0] sh_r;
  initial begin
    sdi_o = 1'b0;
    got_o = '0;
    sh_r  = '0;
  end
  // ==========================================================================
  // Frame start loads the reply word
  always @(negedge sel_n_i) begin
    sh_r  = word_i;
    got_o = '0;
  end
  // Launch on rising clock so the device captures on the falling one
  always @(posedge sclk_i) begin
    if (!sel_n_i) begin
      sdi_o <= #1 sh_r[WORD_BITS-1];
      sh_r = sh_r << 1;
    end
  end
  // Capture on the falling edge, after the device's rising-edge launch
  always @(negedge sclk_i) got_o = {got_o[WORD_BITS-2:0], sdo_i};
  // Released line shows the inverse, so a stale value cannot pass
  always @(posedge sel_n_i) sdi_o <= #1 ~sdi_o;
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for the serial port clocking block
`timescale 1ns/10ps
module testbench;
  import serial_port_pkg::*;
  typedef struct {logic [7:0] div; logic [15:0] tx; logic [15:0] px;} row_type;
  row_type rows [3] = '{'{8'h01, 16'hA5C3, 16'h3C5A}, '{8'h02, 16'h8001, 16'hFFFE},
                        '{8'h05, 16'h7E18, 16'h0F0F}};
  logic clk_i = 0, srst_i = 1, srg_source_select_i = 1, tx_gpio_i = 0, rx_gpio_i = 0;
  logic tx_clock_dir_i = 1, rx_clock_dir_i = 1, tx_frame_dir_i = 1, rx_frame_dir_i = 0;
  logic tx_clock_polarity_i = 1, rx_clock_polarity_i = 1, tx_frame_polarity_i = 1;
  logic rx_frame_polarity_i = 1, tx_start_i = 0, rx_start_i = 0, prev = 0;
  logic tx_bit_clock_i = 0, tx_frame_sync_i = 0, rx_bit_clock_i = 0, rx_frame_sync_i = 0;
  logic [7:0]  clock_divide_value_i = 8'h01;
  logic [1:0]  clock_stop_select_i = CSTOP_SPI, tx_data_delay_i = DLY_0;
  logic [4:0]  gpio_out_i = 5'h00, gpio_in_o;
  logic [15:0] tx_word_i = 16'h0000, peer_word = 16'h0000, rx_word_o, got;
  logic tx_busy_o, rx_valid_o, tx_bit_clock_o, tx_bit_clock_oe_o, tx_frame_sync_o;
  logic tx_frame_sync_oe_o, rx_bit_clock_o, rx_bit_clock_oe_o, rx_frame_sync_o;
  logic rx_frame_sync_oe_o, serial_tx_pin_o, serial_tx_pin_oe_o, serial_rx_pin_i;
  logic srg_clock_out_o;
  int fails = 0, total_checks = 0, run = 0, hi_len = 0, lo_len = 0;
  serial_port_clocking uut (.*);
  // The peer sees whichever side drives each pin
  spi_peer_model peer (.sclk_i(tx_clock_dir_i ? tx_bit_clock_o : tx_bit_clock_i),
    .sel_n_i(tx_frame_dir_i ? tx_frame_sync_o : tx_frame_sync_i),
    .sdo_i(serial_tx_pin_o), .word_i(peer_word), .sdi_o(serial_rx_pin_i), .got_o(got));
  always #10 clk_i = ~clk_i;
  task automatic tick;
    @(posedge clk_i);
    #2;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================================
  // Phase lengths of the generated clock, in CPU cycles
  always @(posedge clk_i) begin
    #1;
    if (tx_bit_clock_o === prev) run++;
    else begin
      if (prev) hi_len = run;
      else lo_len = run;
      if (!prev && !srst_i && tx_clock_dir_i && clock_stop_select_i == CSTOP_SPI)
        chk("select at rise", 16'h0000, 16'(tx_frame_sync_o));
      prev = tx_bit_clock_o;
      run = 1;
    end
  end
  initial begin
    #1_000_000;
    fails++;
    end_sim;
  end
  // ==========================================================================
  // Reset, table of master transfers, framed transmit, SPI slave, then pin GPIO
  initial begin
    int k, d;
    logic s;
    repeat (16) tick;
    chk("tx clock pol", 16'h0001, 16'(tx_bit_clock_o));
    chk("rx clock pol", 16'h0001, 16'(rx_bit_clock_o));
    chk("rx clock oe", 16'h0001, 16'(rx_bit_clock_oe_o));
    chk("busy", 16'h0000, 16'(tx_busy_o));
    srst_i = 0;
    tx_clock_polarity_i = 0;
    rx_clock_polarity_i = 0;
    rx_clock_dir_i = 0;
    $display("reset test done");
    foreach (rows[i]) begin
      d = int'(rows[i].div);
      clock_divide_value_i = rows[i].div;
      peer_word = rows[i].px;
      tx_word_i = rows[i].tx;
      tx_start_i = 1;
      tick;
      tx_start_i = 0;
      for (k = 0; k < 500 && rx_valid_o !== 1'b1; k++) tick;
      chk("rx valid", 16'h0001, 16'(rx_valid_o));
      chk("rx word", rows[i].px, rx_word_o);
      tick;
      chk("peer word", rows[i].tx, got);
      chk("low phase", 16'(d % 2 ? (d + 1) / 2 : d / 2), 16'(lo_len));
      chk("high phase", 16'(d % 2 ? (d + 1) / 2 : d / 2 + 1), 16'(hi_len));
      chk("data oe", 16'h0000, 16'(serial_tx_pin_oe_o));
      chk("select idle", 16'h0001, 16'(tx_frame_sync_o));
      chk("rx clock oe", 16'h0000, 16'(rx_bit_clock_oe_o));
      $display("transfer test %0d done", i);
    end
    // Framed transmit, internal clock and frame, zero data delay
    clock_stop_select_i = 2'h0;
    clock_divide_value_i = 8'h01;
    tx_word_i = 16'h5A3C;
    tx_start_i = 1;
    tick;
    tx_start_i = 0;
    for (k = 0; k < 50 && serial_tx_pin_oe_o !== 1'b1; k++) tick;
    chk("framed sync", 16'h0000, 16'(tx_frame_sync_o));
    for (k = 15; k >= 0; k--) begin
      chk("framed bit", 16'(tx_word_i[k]), 16'(serial_tx_pin_o));
      tick;
      tick;
    end
    chk("framed oe", 16'h0000, 16'(serial_tx_pin_oe_o));
    $display("framed test done");
    // SPI slave: bench drives select and clock, peer answers on data
    clock_stop_select_i = CSTOP_SPI;
    clock_divide_value_i = 8'h05;
    tx_clock_dir_i = 0;
    tx_frame_dir_i = 0;
    srg_source_select_i = 0;
    tx_frame_sync_i = 1;
    peer_word = 16'h96E1;
    tx_word_i = 16'h1B7D;
    tx_start_i = 1;
    tick;
    tx_start_i = 0;
    s = srg_clock_out_o;
    tick;
    chk("srg half rate", 16'(!s), 16'(srg_clock_out_o));
    tx_frame_sync_i = 0;
    repeat (3) tick;
    for (k = 0; k < 16; k++) begin
      tx_bit_clock_i = 1;
      repeat (3) tick;
      tx_bit_clock_i = 0;
      repeat (3) tick;
    end
    chk("slave rx word", 16'h96E1, rx_word_o);
    chk("slave peer word", 16'h1B7D, got);
    chk("slave data oe", 16'h0001, 16'(serial_tx_pin_oe_o));
    tx_frame_sync_i = 1;
    repeat (2) tick;
    chk("slave release", 16'h0000, 16'(serial_tx_pin_oe_o));
    $display("slave test done");
    tx_gpio_i = 1;
    rx_gpio_i = 1;
    gpio_out_i = 5'h15;
    tx_bit_clock_i = 1;
    rx_frame_sync_i = 1;
    tick;
    chk("gpio out", 16'h0015, 16'({serial_tx_pin_o, tx_frame_sync_o, tx_bit_clock_o,
        rx_frame_sync_o, rx_bit_clock_o}));
    chk("gpio in", 16'h000E, 16'({gpio_in_o[4:3], gpio_in_o[1:0]}));
    tick;
    $display("gpio test done");
    end_sim;
  end
endmodule
